// File: rtl/adcp_converter.sv
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module adcp_converter import adcp_pkg::*; #(
    parameter int LVL_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic stop_mode,
    input wire logic wait_mode,
    input wire logic external_trigger_input,
    input wire logic [LVL_W-1:0] analog_level,
    output logic [4:0] channel_select,
    output logic sample_hold,
    output logic converter_active,
    output logic converter_clock_run,
    output logic irq
);
    function automatic logic [9:0] round_code(input logic [LVL_W-1:0] lv, input logic m8);
        logic [LVL_W:0] s10;
        logic [LVL_W:0] s8;
        logic [9:0] c;
        s10 = {1'b0, lv} + (LVL_W+1)'(1 << (LVL_W - 11));
        s8 = {1'b0, lv} + (LVL_W+1)'(1 << (LVL_W - 9));
        if (m8) begin
            c = s8[LVL_W] ? CODE8_MAX : {2'h0, s8[LVL_W-1:LVL_W-8]};
        end else begin
            c = s10[LVL_W] ? CODE10_MAX : s10[LVL_W-1:LVL_W-10];
        end
        return c;
    endfunction

    function automatic logic [2:0] div_limit(input logic [1:0] d);
        logic [2:0] l;
        l = 3'((4'h1 << d) - 4'h1);
        return l;
    endfunction

    // Pin synchronisers.
    logic [LVL_W-1:0] lvl_m_r, lvl_s_r;
    logic trg_m_r, trg_s_r, trg_d_r;
    always_ff @(posedge clk) begin
        lvl_m_r <= analog_level;
        lvl_s_r <= lvl_m_r;
        trg_m_r <= external_trigger_input;
        trg_s_r <= trg_m_r;
        trg_d_r <= rst ? 1'b0 : trg_s_r;
    end

    // Bus data phase state.
    logic ph_v_r, ph_v_nxt, ph_wr_r, ph_wr_nxt, rd_done_r, rd_done_nxt;
    logic [7:0] ph_a_r, ph_a_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;

    // Control state.
    adcp_state_t st_r, st_nxt;
    logic [4:0] chan_r, chan_nxt;
    logic cont_r, cont_nxt, ien_r, ien_nxt, done_r, done_nxt, irqd_r, irqd_nxt;
    logic long_r, long_nxt, mode8_r, mode8_nxt, async_r, async_nxt, hwtrig_r, hwtrig_nxt;
    logic [1:0] div_r, div_nxt;
    logic hi_rd_r, hi_rd_nxt;
    logic [9:0] result_r, result_nxt;
    logic [LVL_W-1:0] held_r, held_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [2:0] pre_r, pre_nxt;
    logic [EVT_W-1:0] evt_r, evt_nxt, mask_r, mask_nxt, evt_set;

    logic addr_ok, rd_fire, wr_fire, wr_sc, wr_cfg, rd_low, rd_res, rd_evt;
    logic clk_ok, half_tick, busy, stop_abort, trig_edge, start_ok;
    logic [5:0] samp_len, conv_len;

    always_comb begin
        addr_ok = hsel & htrans[1] & hready;
        rd_fire = ph_v_r & ~ph_wr_r & ~rd_done_r;
        wr_fire = ph_v_r & ph_wr_r;
        ph_v_nxt = addr_ok ? 1'b1 : (hreadyout ? 1'b0 : ph_v_r);
        ph_wr_nxt = addr_ok ? hwrite : ph_wr_r;
        ph_a_nxt = addr_ok ? haddr[7:0] : ph_a_r;
        rd_done_nxt = rd_fire ? 1'b1 : (hready ? 1'b0 : rd_done_r);
        wr_sc = wr_fire & (ph_a_r == OFS_STATUS_CONTROL);
        wr_cfg = wr_fire & (ph_a_r == OFS_CLOCK_CONFIG);
        rd_low = rd_fire & (ph_a_r == OFS_RESULT_LOW);
        rd_res = rd_low | (rd_fire & (ph_a_r == OFS_RESULT_HIGH));
        rd_evt = rd_fire & (ph_a_r == OFS_EVENT_STATUS);
        hrdata_nxt = hrdata_r;
        if (rd_fire) begin
            unique case (ph_a_r)
                OFS_STATUS_CONTROL: hrdata_nxt = {24'h0, done_r, ien_r, cont_r, chan_r};
                OFS_RESULT_HIGH: hrdata_nxt = {30'h0, result_r[9:8]};
                OFS_RESULT_LOW: hrdata_nxt = {24'h0, result_r[7:0]};
                OFS_CLOCK_CONFIG: hrdata_nxt = {26'h0, hwtrig_r, async_r, div_r, mode8_r, long_r};
                OFS_EVENT_STATUS: hrdata_nxt = {29'h0, evt_r};
                OFS_EVENT_MASK: hrdata_nxt = {29'h0, mask_r};
                OFS_STATE: hrdata_nxt = {25'h0, hi_rd_r, stop_mode, wait_mode, st_r};
                default: hrdata_nxt = 32'h0;
            endcase
        end
    end

    always_comb begin
        st_nxt = st_r;
        chan_nxt = chan_r;
        cont_nxt = cont_r;
        ien_nxt = ien_r;
        long_nxt = long_r;
        mode8_nxt = mode8_r;
        div_nxt = div_r;
        async_nxt = async_r;
        hwtrig_nxt = hwtrig_r;
        result_nxt = result_r;
        held_nxt = held_r;
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        mask_nxt = mask_r;
        evt_set = '0;
        hi_rd_nxt = hi_rd_r;
        busy = (st_r == st_sample) | (st_r == st_convert);
        clk_ok = ~stop_mode | async_r;
        half_tick = busy & clk_ok & (pre_r == div_limit(div_r));
        samp_len = long_r ? SAMPLE_LONG_HALF : SAMPLE_SHORT_HALF;
        conv_len = mode8_r ? CONV8_HALF : CONV10_HALF;
        trig_edge = trg_s_r & ~trg_d_r;
        stop_abort = stop_mode & ~async_r & (st_r != st_idle);
        start_ok = hwdata[SC_CH_LSB +: 5] != CH_OFF;
        // Clearing accesses; a completion in the same cycle as a result read wins below, a control write cancels it.
        done_nxt = (wr_sc | rd_low) ? 1'b0 : done_r;
        irqd_nxt = (wr_sc | rd_res | ~ien_r) ? 1'b0 : irqd_r;
        if (busy && clk_ok) begin
            pre_nxt = half_tick ? 3'h0 : pre_r + 3'h1;
        end
        if (rd_res) begin
            hi_rd_nxt = (ph_a_r == OFS_RESULT_HIGH) & ~mode8_r;
        end
        if (wr_fire && ph_a_r == OFS_EVENT_MASK) begin
            mask_nxt = hwdata[EVT_W-1:0];
        end
        if (wr_sc) begin
            chan_nxt = hwdata[SC_CH_LSB +: 5];
            cont_nxt = hwdata[SC_CONT_BIT];
            ien_nxt = hwdata[SC_IEN_BIT];
            cnt_nxt = 6'h00;
            pre_nxt = 3'h0;
            // Only a control write leaves idle after a stop abort.
            st_nxt = ~start_ok ? st_idle : (hwtrig_r ? st_wait_trig : st_sample);
        end else if (wr_cfg) begin
            long_nxt = hwdata[CFG_LONG_BIT];
            mode8_nxt = hwdata[CFG_MODE8_BIT];
            div_nxt = hwdata[CFG_DIV_LSB +: 2];
            async_nxt = hwdata[CFG_ASYNC_BIT];
            hwtrig_nxt = hwdata[CFG_HWTRIG_BIT];
            st_nxt = st_idle;
        end else if (stop_abort) begin
            st_nxt = st_idle;
            evt_set[EVT_STOP_ABORT] = busy;
        end else begin
            unique case (st_r)
                st_idle: st_nxt = st_idle;
                st_wait_trig: begin
                    if (trig_edge) begin
                        st_nxt = st_sample;
                        cnt_nxt = 6'h00;
                        pre_nxt = 3'h0;
                    end
                end
                st_sample: begin
                    if (half_tick) begin
                        cnt_nxt = cnt_r + 6'h01;
                        if (cnt_r == samp_len - 6'h01) begin
                            held_nxt = lvl_s_r;
                            cnt_nxt = 6'h00;
                            st_nxt = st_convert;
                        end
                    end
                end
                st_convert: begin
                    if (half_tick) begin
                        cnt_nxt = cnt_r + 6'h01;
                        if (cnt_r == conv_len - 6'h01) begin
                            cnt_nxt = 6'h00;
                            if (hi_rd_r && !mode8_r) begin
                                evt_set[EVT_BLOCKED] = 1'b1;
                                st_nxt = st_sample;
                            end else begin
                                result_nxt = round_code(held_r, mode8_r);
                                done_nxt = 1'b1;
                                irqd_nxt = ien_r;
                                evt_set[EVT_COMPLETE] = 1'b1;
                                // Single conversion falls back to low-power idle, or to st_wait_trig when hwtrig_r is set.
                                st_nxt = cont_r ? st_sample : (hwtrig_r ? st_wait_trig : st_idle);
                            end
                        end
                    end
                end
                default: st_nxt = st_idle;
            endcase
        end
        evt_nxt = (rd_evt ? '0 : evt_r) | evt_set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_v_r <= 1'b0;
            ph_wr_r <= 1'b0;
            ph_a_r <= 8'h00;
            rd_done_r <= 1'b0;
            hrdata_r <= 32'h0;
            st_r <= st_idle;
            chan_r <= CH_RESET;
            cont_r <= 1'b0;
            ien_r <= 1'b0;
            done_r <= 1'b0;
            irqd_r <= 1'b0;
            long_r <= 1'b0;
            mode8_r <= 1'b0;
            div_r <= 2'h0;
            async_r <= 1'b0;
            hwtrig_r <= 1'b0;
            hi_rd_r <= 1'b0;
            result_r <= 10'h000;
            held_r <= '0;
            cnt_r <= 6'h00;
            pre_r <= 3'h0;
            evt_r <= '0;
            mask_r <= '0;
        end else begin
            ph_v_r <= ph_v_nxt;
            ph_wr_r <= ph_wr_nxt;
            ph_a_r <= ph_a_nxt;
            rd_done_r <= rd_done_nxt;
            hrdata_r <= hrdata_nxt;
            st_r <= st_nxt;
            chan_r <= chan_nxt;
            cont_r <= cont_nxt;
            ien_r <= ien_nxt;
            done_r <= done_nxt;
            irqd_r <= irqd_nxt;
            long_r <= long_nxt;
            mode8_r <= mode8_nxt;
            div_r <= div_nxt;
            async_r <= async_nxt;
            hwtrig_r <= hwtrig_nxt;
            hi_rd_r <= hi_rd_nxt;
            result_r <= result_nxt;
            held_r <= held_nxt;
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign hreadyout = ~(ph_v_r & ~ph_wr_r & ~rd_done_r);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign channel_select = chan_r;
    assign sample_hold = st_r == st_sample;
    assign converter_active = (st_r == st_sample) | (st_r == st_convert);
    assign converter_clock_run = converter_active & (~stop_mode | async_r);
    assign irq = (irqd_r & ien_r) | (|(evt_r & mask_r));
endmodule // adcp_converter

// File: rtl/adcp_pkg.sv
// Operation
// - Sample window 3.5 or 23.5 converter cycles.
// - Ten-bit gives 1024 codes, eight-bit 256.
// - Result rounded; half-step bottom, 1.5-step top.
// - Done flag sets on every completed conversion.
// - Enabled completion raises processor interrupt request.
// - Wait mode keeps converting and interrupting.
// - Single conversion returns to idle automatically; in hardware-trigger mode the code returns to trigger wait instead.
// - Stop without async clock aborts conversion.
// - After stop, resume only on control write.
// - Stop with async clock keeps converting normally.
// - Stopped hardware-trigger mode with async clock idles until trigger.
// - Control write or low-result read clears done.
// - Result read or control write drops interrupt.
// - Async converter clock keeps running in stop.
package adcp_pkg;
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h08;
    localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h0C;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;
    localparam int SC_CH_LSB = 0;
    localparam int SC_CONT_BIT = 5;
    localparam int SC_IEN_BIT = 6;
    localparam int SC_DONE_BIT = 7;
    localparam int CFG_LONG_BIT = 0;
    localparam int CFG_MODE8_BIT = 1;
    localparam int CFG_DIV_LSB = 2;
    localparam int CFG_ASYNC_BIT = 4;
    localparam int CFG_HWTRIG_BIT = 5;
    localparam int EVT_COMPLETE = 0;
    localparam int EVT_STOP_ABORT = 1;
    localparam int EVT_BLOCKED = 2;
    localparam int EVT_W = 3;
    localparam logic [4:0] CH_OFF = 5'h1F;
    localparam logic [4:0] CH_RESET = 5'h1F;
    localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07;
    localparam logic [5:0] SAMPLE_LONG_HALF = 6'h2F;
    localparam logic [5:0] CONV10_HALF = 6'h14;
    localparam logic [5:0] CONV8_HALF = 6'h10;
    localparam logic [9:0] CODE10_MAX = 10'h3FF;
    localparam logic [9:0] CODE8_MAX = 10'h0FF;
    typedef enum logic [3:0] {
        st_idle = 4'b0001,
        st_wait_trig = 4'b0010,
        st_sample = 4'b0100,
        st_convert = 4'b1000
    } adcp_state_t;
endpackage

// File: verif/adcp_source.sv
`timescale 1ns/1ps
module adcp_source #(
    parameter int LVL_W = 12
) (
    input wire logic [4:0] channel_select,
    output logic [LVL_W-1:0] analog_level
);
    // Each channel presents a fixed level so results can be predicted.
    always_comb begin
        case (channel_select)
            5'h01: analog_level = LVL_W'('h007);
            5'h02: analog_level = LVL_W'('h801);
            5'h03: analog_level = LVL_W'('hFFF);
            default: analog_level = LVL_W'('h5A5);
        endcase
    end
endmodule // adcp_source

// File: verif/adcp_converter_chk.sv
`timescale 1ns/1ps
module adcp_converter_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic stop_mode,
    input wire logic [4:0] channel_select,
    input wire logic sample_hold,
    input wire logic converter_active,
    input wire logic converter_clock_run,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic tk;
    assign tk = hsel && htrans[1] && hready;
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_write_nowait: assert property (tk && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait state");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !converter_active
        && channel_select == 5'h1F) else $error("outputs not quiet after reset");
    a_hold_active: assert property (sample_hold |-> converter_active)
        else $error("sampling while inactive");
    a_sample_len: assert property ($rose(sample_hold) |-> sample_hold [*7])
        else $error("sample window too short");
    a_stop_abort: assert property (stop_mode && converter_active && !converter_clock_run
        |-> ##[1:2] !converter_active) else $error("stop did not abort");
    a_clock_run: assert property (converter_active && !stop_mode |-> converter_clock_run)
        else $error("converter clock stopped while active");
    a_irq_hold: assert property (irq && !$past(tk) |=> irq)
        else $error("interrupt dropped without clearing access");
endmodule // adcp_converter_chk
bind adcp_converter adcp_converter_chk chk_i (.clk, .rst, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .stop_mode, .channel_select, .sample_hold, .converter_active,
    .converter_clock_run, .irq);

// File: verif/adc_conversion_power_control_test.sv
`timescale 1ns/1ps
module adc_conversion_power_control_test;
    import adcp_pkg::*;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, stop_mode, wait_mode, trg;
    logic sh, act, crun, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] lvl;
    logic [4:0] chs;
    int fails, samples_checked, n;
    assign hready = hreadyout;
    adcp_converter uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stop_mode(stop_mode),
        .wait_mode(wait_mode), .external_trigger_input(trg), .analog_level(lvl),
        .channel_select(chs), .sample_hold(sh), .converter_active(act),
        .converter_clock_run(crun), .irq(irq));
    adcp_source src (.channel_select(chs), .analog_level(lvl));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'h1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'h0, 32'h0);
        chk(hrdata, exp);
    endtask
    task automatic cnt_hold(input int lim);
        n = 0;
        repeat (lim) begin
            @(posedge clk);
            if (sh === 1'h1) n++;
        end
    endtask
    task automatic single_run;
        wait_mode <= 1'h1;
        wr(OFS_CLOCK_CONFIG, 32'h0);
        wr(OFS_STATUS_CONTROL, 32'h43);
        cnt_hold(60);
        chk(n, 32'h7);
        chk(irq, 1'h1);
        chk(act, 1'h0);
        rdc(OFS_STATUS_CONTROL, 32'hC3);
        rdc(OFS_RESULT_HIGH, 32'h3);
        rdc(OFS_RESULT_LOW, 32'hFF);
        chk(irq, 1'h0);
        rdc(OFS_STATUS_CONTROL, 32'h43);
        wait_mode <= 1'h0;
    endtask
    task automatic long8_run;
        wr(OFS_CLOCK_CONFIG, 32'h3);
        wr(OFS_STATUS_CONTROL, 32'h1);
        cnt_hold(80);
        chk(n, 32'h2F);
        chk(irq, 1'h0);
        rdc(OFS_STATUS_CONTROL, 32'h81);
        rdc(OFS_RESULT_HIGH, 32'h0);
        rdc(OFS_RESULT_LOW, 32'h0);
        wr(OFS_EVENT_MASK, 32'h1);
        @(posedge clk);
        chk(irq, 1'h1);
        rdc(OFS_EVENT_STATUS, 32'h1);
        chk(irq, 1'h0);
        wr(OFS_EVENT_MASK, 32'h0);
    endtask
    task automatic stop_abort;
        wr(OFS_CLOCK_CONFIG, 32'h0);
        wr(OFS_STATUS_CONTROL, 32'h2);
        repeat (15) @(posedge clk);
        stop_mode <= 1'h1;
        repeat (3) @(posedge clk);
        chk(act, 1'h0);
        stop_mode <= 1'h0;
        repeat (40) @(posedge clk);
        chk(act, 1'h0);
        rdc(OFS_RESULT_HIGH, 32'h0);
        rdc(OFS_RESULT_LOW, 32'h0);
        rdc(OFS_EVENT_STATUS, 32'h2);
        wr(OFS_STATUS_CONTROL, 32'h2);
        cnt_hold(40);
        rdc(OFS_RESULT_HIGH, 32'h2);
        rdc(OFS_RESULT_LOW, 32'h0);
    endtask
    task automatic stop_trigger;
        wr(OFS_CLOCK_CONFIG, 32'h30);
        wr(OFS_STATUS_CONTROL, 32'h43);
        stop_mode <= 1'h1;
        repeat (20) @(posedge clk);
        chk(act, 1'h0);
        trg <= 1'h1;
        repeat (6) @(posedge clk);
        chk(act, 1'h1);
        chk(crun, 1'h1);
        trg <= 1'h0;
        repeat (80) begin
            @(posedge clk);
            if (irq === 1'h1) break;
        end
        chk(irq, 1'h1);
        rdc(OFS_RESULT_LOW, 32'hFF);
        stop_mode <= 1'h0;
    endtask
    task automatic cont_blocked;
        wr(OFS_CLOCK_CONFIG, 32'h4);
        wr(OFS_STATUS_CONTROL, 32'h21);
        cnt_hold(54);
        chk(n, 32'hE);
        rdc(OFS_STATUS_CONTROL, 32'hA1);
        chk(act, 1'h1);
        rdc(OFS_RESULT_HIGH, 32'h0);
        cnt_hold(60);
        rdc(OFS_RESULT_LOW, 32'h2);
        rdc(OFS_EVENT_STATUS, 32'h5);
        wr(OFS_STATUS_CONTROL, 32'h1F);
        @(posedge clk);
        chk(act, 1'h0);
        rdc(OFS_STATUS_CONTROL, 32'h1F);
    endtask
    task automatic finish_test;
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        rst = 1'h1;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stop_mode = 1'h0;
        wait_mode = 1'h0;
        trg = 1'h0;
        fails = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        rdc(OFS_STATUS_CONTROL, 32'h1F);
        rdc(8'h40, 32'h0);
        single_run;
        long8_run;
        stop_abort;
        stop_trigger;
        cont_blocked;
        finish_test;
    end
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        finish_test;
    end
endmodule // adc_conversion_power_control_test
